// ===== afcs_control.sv
`timescale 1ns/1ns
`default_nettype none
// ============================================================================
// feature control select: registers or straps drive the datapath settings
// ============================================================================
module afcs_control
  import afcs_pkg::*;
(
  input wire logic i_ref_clk,               // 100 mhz clock
  input wire logic i_rst,                   // synchronous reset
  input wire logic i_mode_strap,            // low selects extended mode
  input wire logic [1:0] i_clocking_strap,  // three-level clocking strap
  input wire logic i_level_strap,           // swing strap
  input wire logic i_range_strap,           // range strap
  input wire logic [1:0] i_interleave_strap,// dual-edge strap
  input wire logic i_serial_clk,            // serial clock
  input wire logic i_serial_data_in,        // serial data
  input wire logic i_serial_select_n,       // serial select, active low
  output logic o_double_rate,               // ddr output clocking
  output logic o_ddr_clock_phase_sel,       // ddr phase select
  output logic o_sdr_edge_rising,           // sdr data on rising edge
  output logic o_swing_normal,              // normal lvds swing
  output logic [8:0] o_i_range,             // i channel range code
  output logic [8:0] o_q_range,             // q channel range code
  output logic [8:0] o_i_offset,            // i channel offset code
  output logic [8:0] o_q_offset,            // q channel offset code
  output logic o_interleave,                // dual-edge sampling on
  output logic o_interleave_q_sel,          // q input feeds both converters
  output logic o_test_pattern,              // test pattern on data outputs
  output logic o_output_clock_always,       // output clock runs continuously
  output logic o_non_demux,                 // non-demultiplexed output
  output logic o_second_clock,              // out-of-range pair carries clock
  output logic [7:0] o_phase_coarse_mid,    // coarse and intermediate phase
  output logic [7:0] o_phase_fine,          // fine phase
  output logic o_phase_adjust_en            // manual phase in use
);

  logic ext_mode;                            // extended control active
  logic mode_q, next_mode_q;                 // previous mode, for entry edge
  logic rx_wr;
  logic [3:0] rx_addr;
  logic [15:0] rx_data;
  logic [15:0] output_config, next_output_config;
  logic [15:0] i_offset_adjust, next_i_offset_adjust;
  logic [15:0] i_fullscale_adjust, next_i_fullscale_adjust;
  logic [15:0] extended_config, next_extended_config;
  logic [15:0] q_offset_adjust, next_q_offset_adjust;
  logic [15:0] q_fullscale_adjust, next_q_fullscale_adjust;
  logic [15:0] sample_phase_fine, next_sample_phase_fine;
  logic [15:0] sample_phase_coarse_mid, next_sample_phase_coarse_mid;
  logic s_double_rate, s_edge_rising, s_swing_normal, s_interleave;
  logic [8:0] s_range;
  logic [27:0] next_out, out_q;              // packed routed settings
  logic [8:0] next_i_range, next_q_range, next_i_offset, next_q_offset;
  logic [8:0] i_range_q, q_range_q, i_offset_q, q_offset_q;
  logic [15:0] next_phase, phase_q;

  assign ext_mode = !i_mode_strap;           // strap may change while running

  // ==========================================================================
  // serial port and strap decode
  // ==========================================================================
  afcs_serial_rx u_rx (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_enable(ext_mode),
    .i_serial_clk(i_serial_clk),
    .i_serial_data_in(i_serial_data_in),
    .i_serial_select_n(i_serial_select_n),
    .o_wr(rx_wr),
    .o_addr(rx_addr),
    .o_data(rx_data)
  );

  afcs_strap_decode u_strap (
    .i_clocking_strap(i_clocking_strap),
    .i_level_strap(i_level_strap),
    .i_range_strap(i_range_strap),
    .i_interleave_strap(i_interleave_strap),
    .o_double_rate(s_double_rate),
    .o_edge_rising(s_edge_rising),
    .o_swing_normal(s_swing_normal),
    .o_range(s_range),
    .o_interleave(s_interleave)
  );

  // ==========================================================================
  // register file: defaults on entry to extended mode, then host writes
  // ==========================================================================
  // reset also loads defaults; real silicon powers up unknown in extended
  // mode, so the host must still program every register first
  always_comb begin
    next_mode_q = ext_mode;
    next_output_config = output_config;
    next_i_offset_adjust = i_offset_adjust;
    next_i_fullscale_adjust = i_fullscale_adjust;
    next_extended_config = extended_config;
    next_q_offset_adjust = q_offset_adjust;
    next_q_fullscale_adjust = q_fullscale_adjust;
    next_sample_phase_fine = sample_phase_fine;
    next_sample_phase_coarse_mid = sample_phase_coarse_mid;
    if (ext_mode && !mode_q) begin
      // moving from pin mode to extended mode loads defaults
      next_output_config = AFCS_OUTPUT_CONFIG_DEF;
      next_i_offset_adjust = AFCS_OFFSET_DEF;
      next_i_fullscale_adjust = AFCS_FULLSCALE_DEF;
      next_extended_config = AFCS_EXTENDED_CONFIG_DEF;
      next_q_offset_adjust = AFCS_OFFSET_DEF;
      next_q_fullscale_adjust = AFCS_FULLSCALE_DEF;
      next_sample_phase_fine = AFCS_PHASE_DEF;
      next_sample_phase_coarse_mid = AFCS_PHASE_DEF;
    end else if (rx_wr) begin
      // unmapped and reserved addresses are dropped
      case (rx_addr)
        AFCS_OUTPUT_CONFIG: next_output_config = rx_data;
        AFCS_I_OFFSET_ADJUST: next_i_offset_adjust = rx_data;
        AFCS_I_FULLSCALE_ADJUST: next_i_fullscale_adjust = rx_data;
        AFCS_EXTENDED_CONFIG: next_extended_config = rx_data;
        AFCS_Q_OFFSET_ADJUST: next_q_offset_adjust = rx_data;
        AFCS_Q_FULLSCALE_ADJUST: next_q_fullscale_adjust = rx_data;
        AFCS_SAMPLE_PHASE_FINE: next_sample_phase_fine = rx_data;
        AFCS_SAMPLE_PHASE_COARSE_MID: next_sample_phase_coarse_mid = rx_data;
        default: next_output_config = output_config;
      endcase
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      mode_q <= 1'b0;
      output_config <= AFCS_OUTPUT_CONFIG_DEF;
      i_offset_adjust <= AFCS_OFFSET_DEF;
      i_fullscale_adjust <= AFCS_FULLSCALE_DEF;
      extended_config <= AFCS_EXTENDED_CONFIG_DEF;
      q_offset_adjust <= AFCS_OFFSET_DEF;
      q_fullscale_adjust <= AFCS_FULLSCALE_DEF;
      sample_phase_fine <= AFCS_PHASE_DEF;
      sample_phase_coarse_mid <= AFCS_PHASE_DEF;
    end else begin
      mode_q <= next_mode_q;
      output_config <= next_output_config;
      i_offset_adjust <= next_i_offset_adjust;
      i_fullscale_adjust <= next_i_fullscale_adjust;
      extended_config <= next_extended_config;
      q_offset_adjust <= next_q_offset_adjust;
      q_fullscale_adjust <= next_q_fullscale_adjust;
      sample_phase_fine <= next_sample_phase_fine;
      sample_phase_coarse_mid <= next_sample_phase_coarse_mid;
    end
  end

  // ==========================================================================
  // routing: straps in pin mode, registers in extended mode
  // ==========================================================================
  always_comb begin
    next_out = 28'h000_0000;
    if (ext_mode) begin
      next_out[0] = !output_config[AFCS_DOUBLE_RATE_DISABLE_BIT];
      next_out[1] = output_config[AFCS_DDR_CLOCK_PHASE_SEL_BIT];
      next_out[2] = output_config[AFCS_OUTPUT_EDGE_DEMUX_SEL_BIT];
      next_out[3] = output_config[AFCS_OUTPUT_SWING_SEL_BIT];
      next_out[4] = extended_config[AFCS_INTERLEAVE_ENABLE_BIT];
      next_out[5] = extended_config[AFCS_INTERLEAVE_Q_SEL_BIT];
      next_out[6] = extended_config[AFCS_TEST_PATTERN_ENABLE_BIT];
      next_out[7] = extended_config[AFCS_TRIM_DISABLE_BIT];
      // demux choice only means something with ddr clocking
      next_out[8] = !output_config[AFCS_DOUBLE_RATE_DISABLE_BIT] &&
                    output_config[AFCS_OUTPUT_EDGE_DEMUX_SEL_BIT];
      next_out[9] = !output_config[AFCS_SECOND_CLOCK_DISABLE_BIT];
      next_out[10] = 1'b1;
    end else begin
      next_out[0] = s_double_rate;
      next_out[1] = 1'b0;
      next_out[2] = s_edge_rising;
      next_out[3] = s_swing_normal;
      next_out[4] = s_interleave;
      next_out[5] = 1'b0;
      // test pattern, trim, demux, second clock and phase stay off
    end
  end

  // ==========================================================================
  // adjustment fields
  // ==========================================================================
  always_comb begin
    if (ext_mode) begin
      next_i_range = afcs_adj_field(i_fullscale_adjust);
      next_q_range = afcs_adj_field(q_fullscale_adjust);
      next_i_offset = afcs_adj_field(i_offset_adjust);
      next_q_offset = afcs_adj_field(q_offset_adjust);
      next_phase = {sample_phase_coarse_mid[AFCS_COARSE_MSB:AFCS_COARSE_LSB],
                    sample_phase_fine[AFCS_FINE_MSB:AFCS_FINE_LSB]};
    end else begin
      next_i_range = s_range;
      next_q_range = s_range;
      next_i_offset = AFCS_ADJ_NONE;
      next_q_offset = AFCS_ADJ_NONE;
      next_phase = 16'h0000;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      out_q <= 28'h000_0000;
      i_range_q <= AFCS_ADJ_NORMAL;
      q_range_q <= AFCS_ADJ_NORMAL;
      i_offset_q <= AFCS_ADJ_NONE;
      q_offset_q <= AFCS_ADJ_NONE;
      phase_q <= 16'h0000;
    end else begin
      out_q <= next_out;
      i_range_q <= next_i_range;
      q_range_q <= next_q_range;
      i_offset_q <= next_i_offset;
      q_offset_q <= next_q_offset;
      phase_q <= next_phase;
    end
  end

  assign o_double_rate = out_q[0];
  assign o_ddr_clock_phase_sel = out_q[1];
  assign o_sdr_edge_rising = out_q[2];
  assign o_swing_normal = out_q[3];
  assign o_interleave = out_q[4];
  assign o_interleave_q_sel = out_q[5];
  assign o_test_pattern = out_q[6];
  assign o_output_clock_always = out_q[7];
  assign o_non_demux = out_q[8];
  assign o_second_clock = out_q[9];
  assign o_phase_adjust_en = out_q[10];
  assign o_i_range = i_range_q;
  assign o_q_range = q_range_q;
  assign o_i_offset = i_offset_q;
  assign o_q_offset = q_offset_q;
  assign o_phase_coarse_mid = phase_q[15:8];
  assign o_phase_fine = phase_q[7:0];

endmodule
`default_nettype wire

// ===== afcs_control_monitor.sv
`timescale 1ns/1ns
`default_nettype none
// ====================
// port checker for the feature select
module afcs_control_monitor (
  input wire logic i_ref_clk, i_rst, i_mode_strap, i_level_strap, i_range_strap,
  input wire logic [1:0] i_clocking_strap, i_interleave_strap,
  input wire logic o_double_rate, o_ddr_clock_phase_sel, o_sdr_edge_rising, o_swing_normal,
  input wire logic o_interleave, o_interleave_q_sel, o_test_pattern, o_output_clock_always,
  input wire logic o_non_demux, o_second_clock, o_phase_adjust_en,
  input wire logic [8:0] o_i_range, o_q_range, o_i_offset, o_q_offset
);
  logic [1:0] pin_cnt; // settled cycles in pin mode, saturating
  logic [6:0] sp1, sp2; // strap history
  logic calm; // straps unchanged for three samples
  // settle counter hides the mode-change latency from the checks
  always_ff @(posedge i_ref_clk) begin
    pin_cnt <= (i_rst || !i_mode_strap) ? 2'h0 : pin_cnt + {1'b0, pin_cnt != 2'h3};
    sp1 <= {i_level_strap, i_range_strap, i_clocking_strap, i_interleave_strap, 1'b0};
    sp2 <= sp1;
  end
  always_comb begin
    calm = ({i_level_strap, i_range_strap, i_clocking_strap, i_interleave_strap, 1'b0} == sp1)
      && (sp1 == sp2);
  end
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  sequence pin_settled; pin_cnt == 2'h3; endsequence
  sequence ext_entry; $fell(i_mode_strap) ##1 !i_mode_strap; endsequence
  chk_pin_fixed: assert property (pin_settled |-> !o_ddr_clock_phase_sel && !o_test_pattern
    && !o_output_clock_always && !o_second_clock && !o_non_demux && !o_phase_adjust_en)
    else $error("pin mode shows an extended-only feature");
  chk_pin_offset: assert property (pin_settled |-> o_i_offset == 9'h100 && o_q_offset == 9'h100)
    else $error("pin mode offset not neutral");
  chk_pin_swing: assert property (pin_settled and calm |-> o_swing_normal == i_level_strap)
    else $error("swing does not follow strap");
  chk_pin_range: assert property (pin_settled and calm |-> o_q_range == o_i_range
    && o_i_range == (i_range_strap ? 9'h100 : 9'h000)) else $error("range does not follow strap");
  chk_pin_clocking: assert property (pin_settled and calm |->
    o_double_rate == (i_clocking_strap == 2'b01) && (i_clocking_strap != 2'b10 || o_sdr_edge_rising)
    && (i_clocking_strap != 2'b00 || !o_sdr_edge_rising)) else $error("clocking strap misread");
  chk_pin_dual: assert property (pin_settled and calm |-> !o_interleave_q_sel
    && o_interleave == (i_interleave_strap == 2'b01)) else $error("dual-edge strap misread");
  chk_entry_defaults: assert property (ext_entry |-> ##3 o_double_rate && o_swing_normal
    && !o_non_demux && !o_second_clock && !o_interleave && o_i_offset == 9'h000
    && o_i_range == 9'h100 && o_phase_adjust_en) else $error("defaults not loaded on entry");
  chk_demux_ddr: assert property (o_non_demux |-> o_double_rate)
    else $error("non-demux without ddr");
endmodule
bind afcs_control afcs_control_monitor u_mon (.i_ref_clk, .i_rst, .i_mode_strap, .i_level_strap,
  .i_range_strap, .i_clocking_strap, .i_interleave_strap, .o_double_rate, .o_ddr_clock_phase_sel,
  .o_sdr_edge_rising, .o_swing_normal, .o_interleave, .o_interleave_q_sel, .o_test_pattern,
  .o_output_clock_always, .o_non_demux, .o_second_clock, .o_phase_adjust_en, .o_i_range,
  .o_q_range, .o_i_offset, .o_q_offset);
`default_nettype wire

// ===== afcs_control_test.sv
`timescale 1ns/1ns
`default_nettype none
module afcs_control_test;
  import afcs_pkg::*;
  // ====================
  // stimulus and reference state
  logic i_ref_clk = 1'b0;
  logic i_rst = 1'b1;
  logic mode = 1'b1; // start in pin mode
  logic lvl = 1'b0;
  logic rng = 1'b0;
  logic [1:0] clk_s = 2'b00;
  logic [1:0] ilv_s = 2'b00;
  wire sclk, sdat, ssel_n;
  wire [62:0] got; // every output, packed
  logic [15:0] r [16]; // reference copy of the write-only registers
  logic [3:0] tbl [13] = '{4'h1, 4'h2, 4'h3, 4'h9, 4'ha, 4'hb, 4'hd, 4'hf, 4'h0, 4'h4, 4'hc,
    4'he, 4'h1}; // eight registers, ignored places, then a bad header
  int miscompares = 0;
  int check_count = 0;
  int seed = 32'hf65ae79a;
  afcs_control DUT (.i_ref_clk, .i_rst, .i_mode_strap(mode), .i_clocking_strap(clk_s),
    .i_level_strap(lvl), .i_range_strap(rng), .i_interleave_strap(ilv_s), .i_serial_clk(sclk),
    .i_serial_data_in(sdat), .i_serial_select_n(ssel_n), .o_double_rate(got[62]),
    .o_ddr_clock_phase_sel(got[61]), .o_sdr_edge_rising(got[60]), .o_swing_normal(got[59]),
    .o_interleave(got[58]), .o_interleave_q_sel(got[57]), .o_test_pattern(got[56]),
    .o_output_clock_always(got[55]), .o_non_demux(got[54]), .o_second_clock(got[53]),
    .o_phase_adjust_en(got[52]), .o_i_range(got[51:43]), .o_q_range(got[42:34]),
    .o_i_offset(got[33:25]), .o_q_offset(got[24:16]), .o_phase_coarse_mid(got[15:8]),
    .o_phase_fine(got[7:0]));
  afcs_host_model host (.i_ref_clk, .o_serial_clk(sclk), .o_serial_data_in(sdat),
    .o_serial_select_n(ssel_n));
  initial forever #5 i_ref_clk = ~i_ref_clk;
  // expected outputs; in extended mode the sdr edge follows the edge/demux bit
  function automatic logic [62:0] expv();
    logic [15:0] c;
    logic [15:0] e;
    c = r[1];
    e = r[9];
    if (mode) return {clk_s == 2'b01, 1'b0, clk_s == 2'b10, lvl, ilv_s == 2'b01, 6'h00,
      {2{(rng ? 9'h100 : 9'h000)}}, 18'h20100, 16'h0000};
    return {!c[10], c[11], c[8], c[9], e[13], e[12], e[15], e[14], !c[10] && c[8], !c[13], 1'b1,
      r[3][15:7], r[11][15:7], r[2][15:7], r[10][15:7], r[15][14:7], r[13][15:8]};
  endfunction
  task check;
    check_count++;
    if (got !== expv()) begin
      miscompares++;
      $display("ERROR outputs expected %h seen %h", expv(), got);
    end
  endtask
  task defaults;
    r[1] = AFCS_OUTPUT_CONFIG_DEF;
    r[2] = AFCS_OFFSET_DEF;
    r[10] = AFCS_OFFSET_DEF;
    r[3] = AFCS_FULLSCALE_DEF;
    r[11] = AFCS_FULLSCALE_DEF;
    r[9] = AFCS_EXTENDED_CONFIG_DEF;
    r[13] = AFCS_PHASE_DEF;
    r[15] = AFCS_PHASE_DEF;
  endtask
  task finish_test;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // ====================
  // main sequence: pin straps, mode entry, write rounds, reset, back to pin
  initial begin
    repeat (12) @(posedge i_ref_clk);
    i_rst <= 1'b0;
    for (int k = 0; k < 9; k++) begin
      @(posedge i_ref_clk);
      clk_s <= 2'(k % 3);
      ilv_s <= 2'((k / 3) % 3);
      lvl <= 1'($random(seed));
      rng <= 1'($random(seed));
      repeat (4) @(posedge i_ref_clk);
      check();
    end
    host.send(AFCS_HDR_PATTERN, AFCS_OUTPUT_CONFIG, 16'h0000, 2, 1'b1);
    repeat (5) @(posedge i_ref_clk);
    check();
    mode <= 1'b0; // strap falls to extended mode here, after pin mode has settled
    defaults();
    repeat (6) @(posedge i_ref_clk);
    check();
    // host programs every register; last round uses a slow serial clock
    for (int n = 0; n < 3; n++) begin
      for (int j = 0; j < 13; j++) begin
        logic [15:0] d;
        d = 16'($random(seed));
        host.send(j == 12 ? 12'h003 : AFCS_HDR_PATTERN, tbl[j], d, n == 2 ? 4 : 2, j == 12);
        if (j < 8) r[tbl[j]] = d;
      end
      repeat (5) @(posedge i_ref_clk);
      check();
    end
    i_rst <= 1'b1;
    repeat (12) @(posedge i_ref_clk);
    i_rst <= 1'b0;
    defaults();
    repeat (4) @(posedge i_ref_clk);
    check();
    mode <= 1'b1;
    repeat (5) @(posedge i_ref_clk);
    check();
    finish_test();
  end
  // watchdog against a hung handshake
  initial begin
    repeat (40000) @(posedge i_ref_clk);
    miscompares++;
    finish_test();
  end
endmodule
`default_nettype wire

// ===== afcs_host_model.sv
`timescale 1ns/1ns
`default_nettype none
// ====================
// host side of the three-wire write port
module afcs_host_model (
  input wire logic i_ref_clk, // pacing clock
  output logic o_serial_clk, // idle low outside frames
  output logic o_serial_data_in, // serial data
  output logic o_serial_select_n // select, active low
);
  initial begin
    o_serial_clk = 1'b0;
    o_serial_data_in = 1'b0;
    o_serial_select_n = 1'b1;
  end
  // one write, msb first; hold sets cycles per serial clock phase
  task automatic send(input logic [11:0] hdr, input logic [3:0] adr, input logic [15:0] dat,
    input int hold, input bit last);
    logic [31:0] w;
    w = {hdr, adr, dat};
    for (int k = 31; k >= 0; k--) begin
      @(posedge i_ref_clk);
      o_serial_select_n <= 1'b0;
      o_serial_clk <= 1'b0;
      o_serial_data_in <= w[k];
      repeat (hold) @(posedge i_ref_clk);
      o_serial_clk <= 1'b1;
      repeat (hold - 1) @(posedge i_ref_clk);
    end
    @(posedge i_ref_clk);
    // stay selected for a back-to-back write, else release
    if (last) begin
      o_serial_select_n <= 1'b1;
      o_serial_clk <= 1'b0;
      o_serial_data_in <= ~w[0]; // no stale bit left on the line
    end
  endtask
endmodule
`default_nettype wire

// ===== afcs_pkg.sv
package afcs_pkg;

  // ==========================================================================
  // serial frame layout
  // ==========================================================================
  localparam int AFCS_FRAME_BITS = 32;            // one register write
  localparam int AFCS_HDR_BITS = 12;              // fixed header length
  localparam logic [11:0] AFCS_HDR_PATTERN = 12'h001; // eleven zeros then a one
  localparam int AFCS_ADDR_MSB = 19;              // address field in the shifted word
  localparam int AFCS_ADDR_LSB = 16;
  localparam int AFCS_DATA_MSB = 15;
  localparam int AFCS_HDR_LSB = 20;

  // ==========================================================================
  // register offsets
  // ==========================================================================
  localparam logic [3:0] AFCS_OUTPUT_CONFIG = 4'h1;
  localparam logic [3:0] AFCS_I_OFFSET_ADJUST = 4'h2;
  localparam logic [3:0] AFCS_I_FULLSCALE_ADJUST = 4'h3;
  localparam logic [3:0] AFCS_EXTENDED_CONFIG = 4'h9;
  localparam logic [3:0] AFCS_Q_OFFSET_ADJUST = 4'ha;
  localparam logic [3:0] AFCS_Q_FULLSCALE_ADJUST = 4'hb;
  localparam logic [3:0] AFCS_SAMPLE_PHASE_FINE = 4'hd;
  localparam logic [3:0] AFCS_SAMPLE_PHASE_COARSE_MID = 4'hf;

  // ==========================================================================
  // field positions
  // ==========================================================================
  localparam int AFCS_SECOND_CLOCK_DISABLE_BIT = 13;
  localparam int AFCS_DDR_CLOCK_PHASE_SEL_BIT = 11;
  localparam int AFCS_DOUBLE_RATE_DISABLE_BIT = 10;
  localparam int AFCS_OUTPUT_SWING_SEL_BIT = 9;
  localparam int AFCS_OUTPUT_EDGE_DEMUX_SEL_BIT = 8;
  localparam int AFCS_TEST_PATTERN_ENABLE_BIT = 15;
  localparam int AFCS_TRIM_DISABLE_BIT = 14;
  localparam int AFCS_INTERLEAVE_ENABLE_BIT = 13;
  localparam int AFCS_INTERLEAVE_Q_SEL_BIT = 12;  // input chosen for dual-edge sampling
  localparam int AFCS_ADJ_MSB = 15;               // nine-bit range and offset fields
  localparam int AFCS_ADJ_LSB = 7;
  localparam int AFCS_COARSE_MSB = 14;
  localparam int AFCS_COARSE_LSB = 7;
  localparam int AFCS_FINE_MSB = 15;
  localparam int AFCS_FINE_LSB = 8;

  // ==========================================================================
  // default values loaded on entry to extended mode, and strap-mode codes
  // ==========================================================================
  localparam logic [15:0] AFCS_OUTPUT_CONFIG_DEF = 16'hb2ff;
  localparam logic [15:0] AFCS_OFFSET_DEF = 16'h007f;      // no offset adjustment
  localparam logic [15:0] AFCS_FULLSCALE_DEF = 16'h807f;   // nominal mid-scale range
  localparam logic [15:0] AFCS_EXTENDED_CONFIG_DEF = 16'h03ff;
  localparam logic [15:0] AFCS_PHASE_DEF = 16'h0000;       // no phase adjustment
  localparam logic [8:0] AFCS_ADJ_NORMAL = 9'h100;         // strap normal range
  localparam logic [8:0] AFCS_ADJ_REDUCED = 9'h000;        // strap reduced range
  localparam logic [8:0] AFCS_ADJ_NONE = 9'h100;           // no offset

  // strap three-level encoding for the clocking and dual-edge pins
  typedef enum logic [1:0] {
    AFCS_TRI_LOW = 2'b00,
    AFCS_TRI_MID = 2'b01,
    AFCS_TRI_HIGH = 2'b10
  } afcs_tri_t;

  function automatic logic [8:0] afcs_adj_field(input logic [15:0] r);
    afcs_adj_field = r[AFCS_ADJ_MSB:AFCS_ADJ_LSB];
  endfunction

endpackage

// ===== afcs_serial_rx.sv
`timescale 1ns/1ns
`default_nettype none
// ============================================================================
// serial receiver: samples the serial clock as a plain input, shifts on its
// rising edge while enabled and select is low, and pulses a write after 32 bits with a good header
// ============================================================================
module afcs_serial_rx
  import afcs_pkg::*;
(
  input wire logic i_ref_clk,          // system clock
  input wire logic i_rst,              // synchronous reset
  input wire logic i_enable,           // port live only in extended mode
  input wire logic i_serial_clk,       // host serial clock level
  input wire logic i_serial_data_in,   // host serial data
  input wire logic i_serial_select_n,  // host select, active low
  output logic o_wr,                   // one-cycle write pulse
  output logic [3:0] o_addr,           // register address
  output logic [15:0] o_data           // register data
);

  logic sclk_q, next_sclk_q;           // previous serial clock level
  logic [31:0] shift, next_shift;      // frame shift register
  logic [5:0] count, next_count;       // bits taken in this frame
  logic wr, next_wr;
  logic [3:0] addr, next_addr;
  logic [15:0] data, next_data;
  logic [31:0] word;                   // word including the newest bit

  // ==========================================================================
  // frame assembly
  // ==========================================================================
  always_comb begin
    next_sclk_q = i_serial_clk;
    next_shift = shift;
    next_count = count;
    next_wr = 1'b0;
    next_addr = addr;
    next_data = data;
    word = {shift[30:0], i_serial_data_in};
    if (!i_enable || i_serial_select_n) begin
      // deselect abandons a partial frame
      next_count = 6'h00;
    end else if (i_serial_clk && !sclk_q) begin
      next_shift = word;                                      // msb first
      if (count == 6'(AFCS_FRAME_BITS - 1)) begin
        next_count = 6'h00;                                   // bit 33 starts anew
        // a bad header drops the frame
        if (word[31:AFCS_HDR_LSB] == AFCS_HDR_PATTERN) begin
          next_wr = 1'b1;
          next_addr = word[AFCS_ADDR_MSB:AFCS_ADDR_LSB];
          next_data = word[AFCS_DATA_MSB:0];
        end
      end else begin
        next_count = count + 6'h01;
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      sclk_q <= 1'b0;
      shift <= 32'h0000_0000;
      count <= 6'h00;
      wr <= 1'b0;
      addr <= 4'h0;
      data <= 16'h0000;
    end else begin
      sclk_q <= next_sclk_q;
      shift <= next_shift;
      count <= next_count;
      wr <= next_wr;
      addr <= next_addr;
      data <= next_data;
    end
  end

  assign o_wr = wr;
  assign o_addr = addr;
  assign o_data = data;

endmodule
`default_nettype wire

// ===== afcs_strap_decode.sv
`timescale 1ns/1ns
`default_nettype none
// ============================================================================
// strap decode: turns the pin-mode straps into the same feature settings
// the registers give in extended mode
// ============================================================================
module afcs_strap_decode
  import afcs_pkg::*;
(
  input wire logic [1:0] i_clocking_strap,  // three-level strap, afcs_tri_t code
  input wire logic i_level_strap,           // high normal swing
  input wire logic i_range_strap,           // high normal range
  input wire logic [1:0] i_interleave_strap,// mid level enables dual-edge
  output logic o_double_rate,               // ddr output clocking
  output logic o_edge_rising,               // sdr data on rising edge
  output logic o_swing_normal,              // normal lvds swing
  output logic [8:0] o_range,               // range code for both channels
  output logic o_interleave                 // dual-edge sampling on
);

  // ==========================================================================
  // decode
  // ==========================================================================
  always_comb begin
    o_double_rate = (i_clocking_strap == AFCS_TRI_MID);
    o_edge_rising = (i_clocking_strap == AFCS_TRI_HIGH);
    o_swing_normal = i_level_strap;
    o_range = i_range_strap ? AFCS_ADJ_NORMAL : AFCS_ADJ_REDUCED;
    o_interleave = (i_interleave_strap == AFCS_TRI_MID);
  end

endmodule
`default_nettype wire
